// [verilog/asch_pkg.sv]
// Constants, types and helpers for the ASCII settings command handler
//
// Notes on behaviour
// - Frame is tilde, two hex address digits, command letter, args, checksum, CR.
// - Accepted command answers '!' plus address; rejected one answers '?' plus address.
// - Bad syntax, link error or foreign address gives no answer at all.
// - Settings set takes two hex digits; bit 2 selects range saturation.
// - Saturation select chooses the over/under range reading style downstream.
// - Settings read returns the stored byte as two hex digits.
// - Calibration enable digit 1 enables, digit 0 disables calibration.
// - Calibration requests are refused until calibration has been enabled.
// - Soft init command arms software permission for baud and checksum change.
// - Label set stores up to six characters; later label read returns them.
// - Soft init timeout is two hex digits in seconds, at most sixty.
// - Config change without init pin needs soft init inside the timeout.
// - A zero soft init timeout refuses every software-only config change.
// - Soft init timeout is zero after reset.
// - Double-asterisk host alive frame is taken by all and never answered.
// - Watchdog status read, command digit 0, returns the watchdog status.
// - Status byte: bit 7 watchdog enabled, bit 2 watchdog timeout seen.
// - Timeout flag is kept until the watchdog status clear command.
package asch_pkg;

    //--------------------------------------------------------------
    // Register map and reset values
    //--------------------------------------------------------------
    localparam logic [11:0] ASCH_OFF_CTRL     = 12'h000;
    localparam logic [11:0] ASCH_OFF_STATUS   = 12'h004;
    localparam logic [11:0] ASCH_OFF_LABEL_LO = 12'h008;
    localparam logic [11:0] ASCH_OFF_LABEL_HI = 12'h00c;
    localparam int          ASCH_CTRL_CKS_BIT = 8;
    localparam logic [7:0]  ASCH_ADDR_RST     = 8'h01;
    localparam logic [7:0]  ASCH_MISC_RST     = 8'h00;
    localparam logic [7:0]  ASCH_TMO_RST      = 8'h00;
    localparam int          ASCH_SR_BIT       = 2;
    localparam int          ASCH_WDT_EN_BIT   = 7;
    localparam int          ASCH_WDT_TO_BIT   = 2;
    localparam logic [7:0]  ASCH_TMO_MAX      = 8'h3c;
    localparam logic [3:0]  ASCH_FRAME_MAX    = 4'hc;
    localparam logic [3:0]  ASCH_LABEL_MAX    = 4'h6;

    //--------------------------------------------------------------
    // Timing
    //--------------------------------------------------------------
    localparam int ASCH_SEC_S      = 1;
    localparam int ASCH_CLK_HZ     = 50000000;
    localparam int ASCH_SEC_CYCLES = ASCH_SEC_S * ASCH_CLK_HZ;

    //--------------------------------------------------------------
    // Characters of the command link
    //--------------------------------------------------------------
    localparam logic [7:0] ASCH_CH_TILDE = 8'h7e;
    localparam logic [7:0] ASCH_CH_CR    = 8'h0d;
    localparam logic [7:0] ASCH_CH_OK    = 8'h21;
    localparam logic [7:0] ASCH_CH_BAD   = 8'h3f;
    localparam logic [7:0] ASCH_CH_STAR  = 8'h2a;
    localparam logic [7:0] ASCH_CH_0     = 8'h30;
    localparam logic [7:0] ASCH_CH_1     = 8'h31;
    localparam logic [7:0] ASCH_CMD_MISC = 8'h44;
    localparam logic [7:0] ASCH_CMD_CAL  = 8'h45;
    localparam logic [7:0] ASCH_CMD_ARM  = 8'h49;
    localparam logic [7:0] ASCH_CMD_LBL  = 8'h4f;
    localparam logic [7:0] ASCH_CMD_TMO  = 8'h54;

    //--------------------------------------------------------------
    // Types
    //--------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_HUNT    = 4'b0001,
        ST_COLLECT = 4'b0010,
        ST_DECODE  = 4'b0100,
        ST_SEND    = 4'b1000
    } asch_state_t;

    typedef enum logic [1:0] {
        RPL_NONE = 2'h0,
        RPL_OK   = 2'h1,
        RPL_BAD  = 2'h2
    } asch_reply_t;

    //--------------------------------------------------------------
    // Hex helpers
    //--------------------------------------------------------------
    function automatic logic [4:0] asch_hex_val(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39)
            return {1'b1, c[3:0]};
        else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
            return {1'b1, 4'(c[3:0] + 4'h9)};
        else
            return 5'h00;
    endfunction

    function automatic logic [8:0] asch_hex_pair(input logic [7:0] hi,
                                                 input logic [7:0] lo);
        logic [4:0] h;
        logic [4:0] l;
        h = asch_hex_val(hi);
        l = asch_hex_val(lo);
        return {h[4] & l[4], h[3:0], l[3:0]};
    endfunction

    function automatic logic [7:0] asch_hex_char(input logic [3:0] n);
        return (n < 4'ha) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
    endfunction

endpackage

// [verilog/asch_soft_init.sv]
// Soft init permission window with a seconds counter
`timescale 1ns/100ps

module asch_soft_init import asch_pkg::*; #(
    parameter int unsigned SEC_CYCLES = ASCH_SEC_CYCLES
) (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       arm,
    input  wire logic       consume,
    input  wire logic [7:0] timeout_s,
    // Status
    output logic            window_open
);

    logic [31:0] cyc;
    logic [7:0]  secs;

    // Open on arm with a nonzero timeout, close on timeout, on a zero timeout or on a used change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window_open <= 1'b0;
            cyc         <= 32'h0;
            secs        <= 8'h00;
        end else if (arm) begin
            window_open <= (timeout_s != 8'h00);
            cyc         <= 32'h0;
            secs        <= 8'h00;
        end else if (consume || timeout_s == 8'h00) begin
            window_open <= 1'b0;
        end else if (window_open) begin
            if (cyc == 32'(SEC_CYCLES - 1)) begin
                cyc  <= 32'h0;
                secs <= 8'(secs + 8'h01);
                if (8'(secs + 8'h01) >= timeout_s)
                    window_open <= 1'b0;
            end else begin
                cyc <= 32'(cyc + 32'h1);
            end
        end
    end

endmodule

// [verilog/asch_cmd_handler.sv]
// Tilde command interpreter with APB settings access
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps

module asch_cmd_handler import asch_pkg::*; #(
    parameter int unsigned SEC_CYCLES = ASCH_SEC_CYCLES
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Received characters
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    input  wire logic        rx_error,
    // Reply characters
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    // Watchdog
    input  wire logic        wdt_enabled,
    input  wire logic        wdt_timeout,
    output logic             host_alive,
    // Calibration gate
    input  wire logic        cal_req,
    output logic             cal_grant,
    output logic             cal_deny,
    // Config change gate
    input  wire logic        init_pin_n,
    input  wire logic        cfg_req,
    output logic             cfg_grant,
    output logic             cfg_deny,
    // Settings
    output logic             range_saturation_select,
    output logic             calibration_enabled,
    output logic             soft_init_open
);

    //--------------------------------------------------------------
    // Storage
    //--------------------------------------------------------------
    asch_state_t state;
    logic [7:0]  own_addr, misc, tmo, fsum;
    logic        cks_en, wdt_flag, fbad;
    logic [7:0]  label [0:5];
    logic [3:0]  label_len, flen, tx_cnt;
    logic [7:0]  fbuf [0:15];
    logic [63:0] tx_shift;
    logic [1:0]  init_sync;

    //--------------------------------------------------------------
    // Decode signals
    //--------------------------------------------------------------
    logic [7:0]  ck_a, ck_b, body_sum, rdat, rsum;
    logic [8:0]  ck_rx, addr_rx, arg_rx;
    logic [3:0]  blen, msg_len, head_len;
    logic        good, mine, is_alive, rdat_en;
    logic        do_misc, do_cal, do_arm, do_label, do_tmo, do_wclr;
    logic        init_active, cfg_consume, setup, wr_acc, mapped;
    asch_reply_t reply;
    logic [63:0] msg;
    logic [23:0] tail;
    logic [31:0] rd_mux;

    //--------------------------------------------------------------
    // Frame decode
    //--------------------------------------------------------------
    always_comb begin
        ck_a     = fbuf[4'(flen - 4'd2)];
        ck_b     = fbuf[4'(flen - 4'd1)];
        ck_rx    = asch_hex_pair(ck_a, ck_b);
        body_sum = 8'(fsum - ck_a - ck_b);
        blen     = cks_en ? 4'(flen - 4'd2) : flen;
        // Checksum failure counts as a link error
        good     = !fbad && (!cks_en || (flen >= 4'd2 && ck_rx[8]
                   && ck_rx[7:0] == body_sum));
        addr_rx  = asch_hex_pair(fbuf[0], fbuf[1]);
        arg_rx   = asch_hex_pair(fbuf[3], fbuf[4]);
        is_alive = good && blen == 4'd2 && fbuf[0] == ASCH_CH_STAR
                   && fbuf[1] == ASCH_CH_STAR;
        mine     = good && blen >= 4'd3 && addr_rx[8]
                   && addr_rx[7:0] == own_addr;
        reply    = RPL_NONE;
        rdat_en  = 1'b0;
        rdat     = 8'h00;
        do_misc  = 1'b0;
        do_cal   = 1'b0;
        do_arm   = 1'b0;
        do_label = 1'b0;
        do_tmo   = 1'b0;
        do_wclr  = 1'b0;
        if (mine) begin
            case (fbuf[2])
                ASCH_CMD_MISC: begin
                    if (blen == 4'd3) begin
                        reply   = RPL_OK;
                        rdat_en = 1'b1;
                        rdat    = misc;
                    end else if (blen == 4'd5 && arg_rx[8]) begin
                        reply   = RPL_OK;
                        do_misc = 1'b1;
                    end
                end
                ASCH_CMD_CAL: begin
                    if (blen == 4'd4) begin
                        do_cal = fbuf[3] == ASCH_CH_0
                                 || fbuf[3] == ASCH_CH_1;
                        reply  = do_cal ? RPL_OK : RPL_BAD;
                    end
                end
                ASCH_CMD_ARM: begin
                    if (blen == 4'd3) begin
                        reply  = RPL_OK;
                        do_arm = 1'b1;
                    end
                end
                ASCH_CMD_LBL: begin
                    if (blen >= 4'd4 && blen <= 4'(ASCH_LABEL_MAX + 4'd3)) begin
                        reply    = RPL_OK;
                        do_label = 1'b1;
                    end
                end
                ASCH_CMD_TMO: begin
                    if (blen == 4'd5 && arg_rx[8]) begin
                        do_tmo = arg_rx[7:0] <= ASCH_TMO_MAX;
                        reply  = do_tmo ? RPL_OK : RPL_BAD;
                    end
                end
                ASCH_CH_0: begin
                    if (blen == 4'd3) begin
                        reply   = RPL_OK;
                        rdat_en = 1'b1;
                        rdat    = 8'h00;
                        rdat[ASCH_WDT_EN_BIT] = wdt_enabled;
                        rdat[ASCH_WDT_TO_BIT] = wdt_flag;
                    end
                end
                ASCH_CH_1: begin
                    if (blen == 4'd3) begin
                        reply   = RPL_OK;
                        do_wclr = 1'b1;
                    end
                end
                default: reply = RPL_NONE;
            endcase
        end
    end

    //--------------------------------------------------------------
    // Reply assembly, first character in the low byte
    //--------------------------------------------------------------
    always_comb begin
        msg = {40'h0, asch_hex_char(own_addr[3:0]),
               asch_hex_char(own_addr[7:4]),
               (reply == RPL_OK) ? ASCH_CH_OK : ASCH_CH_BAD};
        if (rdat_en)
            msg[39:24] = {asch_hex_char(rdat[3:0]),
                          asch_hex_char(rdat[7:4])};
        head_len = rdat_en ? 4'd5 : 4'd3;
        rsum     = 8'(msg[7:0] + msg[15:8] + msg[23:16]
                      + msg[31:24] + msg[39:32]);
        tail     = cks_en ? {ASCH_CH_CR, asch_hex_char(rsum[3:0]),
                             asch_hex_char(rsum[7:4])}
                          : {16'h0, ASCH_CH_CR};
        msg      = msg | ({40'h0, tail} << (8 * head_len));
        msg_len  = 4'(head_len + (cks_en ? 4'd3 : 4'd1));
    end

    //--------------------------------------------------------------
    // Frame collection and reply sending
    //--------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= ST_HUNT;
            flen     <= 4'h0;
            fsum     <= 8'h00;
            fbad     <= 1'b0;
            tx_shift <= 64'h0;
            tx_cnt   <= 4'h0;
            tx_valid <= 1'b0;
        end else begin
            unique case (state)
                ST_HUNT: begin
                    if (rx_valid && rx_data == ASCH_CH_TILDE) begin
                        state <= ST_COLLECT;
                        flen  <= 4'h0;
                        fsum  <= ASCH_CH_TILDE;
                        fbad  <= rx_error;
                    end
                end
                ST_COLLECT: begin
                    if (rx_error)
                        fbad <= 1'b1;
                    if (rx_valid) begin
                        if (rx_data == ASCH_CH_CR) begin
                            state <= ST_DECODE;
                        end else if (rx_data == ASCH_CH_TILDE) begin
                            flen <= 4'h0;
                            fsum <= ASCH_CH_TILDE;
                            fbad <= rx_error;
                        end else if (flen == ASCH_FRAME_MAX) begin
                            fbad <= 1'b1;
                        end else begin
                            flen <= 4'(flen + 4'h1);
                            fsum <= 8'(fsum + rx_data);
                        end
                    end
                end
                ST_DECODE: begin
                    if (reply == RPL_NONE) begin
                        state <= ST_HUNT;
                    end else begin
                        state    <= ST_SEND;
                        tx_shift <= msg;
                        tx_cnt   <= msg_len;
                        tx_valid <= 1'b1;
                    end
                end
                ST_SEND: begin
                    if (tx_ready) begin
                        tx_shift <= tx_shift >> 8;
                        tx_cnt   <= 4'(tx_cnt - 4'h1);
                        if (tx_cnt == 4'h1) begin
                            tx_valid <= 1'b0;
                            state    <= ST_HUNT;
                        end
                    end
                end
            endcase
        end
    end

    assign tx_data = tx_shift[7:0];

    // Frame character store
    always_ff @(posedge pclk) begin
        if (state == ST_COLLECT && rx_valid && rx_data != ASCH_CH_CR
            && rx_data != ASCH_CH_TILDE && flen != ASCH_FRAME_MAX)
            fbuf[flen] <= rx_data;
    end

    //--------------------------------------------------------------
    // Settings updated by commands
    //--------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            misc                <= ASCH_MISC_RST;
            tmo                 <= ASCH_TMO_RST;
            calibration_enabled <= 1'b0;
            host_alive          <= 1'b0;
        end else begin
            host_alive <= state == ST_DECODE && is_alive;
            if (state == ST_DECODE) begin
                if (do_misc)
                    misc <= arg_rx[7:0];
                if (do_tmo)
                    tmo <= arg_rx[7:0];
                if (do_cal)
                    calibration_enabled <= fbuf[3] == ASCH_CH_1;
            end
        end
    end

    assign range_saturation_select = misc[ASCH_SR_BIT];

    // Label store, unused slots cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            label_len <= 4'h0;
            for (int i = 0; i < 6; i++)
                label[i] <= 8'h00;
        end else if (state == ST_DECODE && do_label) begin
            label_len <= 4'(blen - 4'd3);
            for (int i = 0; i < 6; i++)
                label[i] <= (4'(i) < 4'(blen - 4'd3)) ? fbuf[i + 3] : 8'h00;
        end
    end

    // Watchdog timeout flag, a new timeout beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wdt_flag <= 1'b0;
        else if (wdt_timeout)
            wdt_flag <= 1'b1;
        else if (state == ST_DECODE && do_wclr)
            wdt_flag <= 1'b0;
    end

    //--------------------------------------------------------------
    // Calibration and config change gates
    //--------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            init_sync <= 2'b11;
        else
            init_sync <= {init_sync[0], init_pin_n};
    end

    assign init_active = !init_sync[1];
    assign cfg_consume = cfg_req && !init_active && soft_init_open;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_grant <= 1'b0;
            cal_deny  <= 1'b0;
            cfg_grant <= 1'b0;
            cfg_deny  <= 1'b0;
        end else begin
            cal_grant <= cal_req && calibration_enabled;
            cal_deny  <= cal_req && !calibration_enabled;
            cfg_grant <= cfg_req && (init_active || soft_init_open);
            cfg_deny  <= cfg_req && !init_active
                         && !soft_init_open;
        end
    end

    asch_soft_init #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_soft_init (
        .pclk        (pclk),
        .presetn     (presetn),
        .arm         (state == ST_DECODE && do_arm),
        .consume     (cfg_consume),
        .timeout_s   (tmo),
        .window_open (soft_init_open)
    );

    //--------------------------------------------------------------
    // APB slave, no wait states
    //--------------------------------------------------------------
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0;
        case (paddr)
            ASCH_OFF_CTRL:
                rd_mux = {23'h0, cks_en, own_addr};
            ASCH_OFF_STATUS:
                rd_mux = {13'h0, wdt_flag, soft_init_open,
                          calibration_enabled, tmo, misc};
            ASCH_OFF_LABEL_LO:
                rd_mux = {label[3], label[2], label[1], label[0]};
            ASCH_OFF_LABEL_HI:
                rd_mux = {4'h0, label_len, 8'h00, label[5], label[4]};
            default:
                mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup)
                prdata <= pwrite ? 32'h0 : rd_mux;
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_addr <= ASCH_ADDR_RST;
            cks_en   <= 1'b0;
        end else if (wr_acc && paddr == ASCH_OFF_CTRL) begin
            own_addr <= pwdata[7:0];
            cks_en   <= pwdata[ASCH_CTRL_CKS_BIT];
        end
    end

endmodule

// [tb/asch_cmd_handler_asserts.sv]
// Port checks for the command handler, bound to its top module
`timescale 1ns/100ps
module asch_cmd_handler_asserts (
    // Watched ports
    input wire logic       pclk, presetn, psel, penable, pready, pslverr,
    input wire logic       tx_valid, tx_ready, host_alive, cal_req,
    input wire logic       cal_grant, cal_deny, calibration_enabled,
    input wire logic       cfg_req, cfg_grant, cfg_deny, soft_init_open,
    input wire logic [7:0] tx_data
);
    // All checks on the bus clock, quiet in reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    rdy_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    err_with_rdy_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    cal_grant_a: assert property (
        cal_req |=> cal_grant == $past(calibration_enabled))
        else $error("calibration grant wrong");
    cal_deny_a: assert property (
        cal_req |=> cal_deny != $past(calibration_enabled))
        else $error("calibration deny wrong");
    cfg_grant_a: assert property (cfg_req && soft_init_open |=> cfg_grant)
        else $error("open window did not grant");
    cfg_deny_a: assert property (
        cfg_deny |-> $past(cfg_req) && !$past(soft_init_open))
        else $error("deny without closed window");
    tx_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply char not held");
    alive_silent_a: assert property (host_alive |=> !tx_valid [*8])
        else $error("reply after host alive");
    // Main scenarios
    cover property (host_alive);
    cover property (cfg_grant);
    cover property (tx_valid && !tx_ready);
endmodule
bind asch_cmd_handler asch_cmd_handler_asserts u_chk (.pclk, .presetn,
    .psel, .penable, .pready, .pslverr, .tx_valid, .tx_ready, .host_alive,
    .cal_req, .cal_grant, .cal_deny, .calibration_enabled, .cfg_req,
    .cfg_grant, .cfg_deny, .soft_init_open, .tx_data);

// [tb/asch_host_model.sv]
// Host model: sends command frames and gathers replies
`timescale 1ns/100ps
module asch_host_model (
    // Link
    input  wire logic       pclk,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic [7:0]      rx_data = 8'h00,
    output logic            rx_valid = 1'b0,
    output logic            tx_ready = 1'b1
);
    logic  slow = 1'b0;
    string rep = "";
    // Reply sink, stalling every other cycle when slow
    always @(posedge pclk) begin
        if (tx_valid && tx_ready)
            rep = {rep, string'(tx_data)};
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
    // Frame with CR appended; idle data is the inverse of the last char
    task automatic send(input string s);
        s = {s, "\r"};
        foreach (s[i]) begin
            @(posedge pclk);
            rx_data <= s[i];
            rx_valid <= 1'b1;
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule

// [tb/asch_cmd_handler_tb_top.sv]
// Self-checking bench for the command handler
`timescale 1ns/100ps
module asch_cmd_handler_tb_top;
    localparam int unsigned SEC = 20;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, rx_error = 1'b0, wdt_enabled = 1'b0;
    logic        wdt_timeout = 1'b0, cal_req = 1'b0, cfg_req = 1'b0;
    logic        init_pin_n = 1'b1, pready, pslverr, tx_valid, tx_ready;
    logic        rx_valid, host_alive, cal_grant, cal_deny, cfg_grant;
    logic        cfg_deny, range_saturation_select, calibration_enabled;
    logic        soft_init_open;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [32:0] rd;
    logic [7:0]  rx_data, tx_data;
    int          err_count = 0, num_checks = 0;
    // Design, host model and clock
    asch_cmd_handler #(.SEC_CYCLES(SEC)) dut (.*);
    asch_host_model host (.*);
    initial forever #10 pclk = ~pclk;
    task automatic ck(string n, logic [32:0] e, logic [32:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // One APB transfer; error bit and read data land in rd
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d = 32'h0);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = {pslverr, prdata};
        {psel, penable} <= 2'b00;
    endtask
    // Send a frame and compare the whole reply, empty meaning silence
    task automatic xf(string c, string e);
        if (e != "") e = {e, "\r"};
        host.rep = "";
        host.send(c);
        for (int i = 0; i < 60 && (e == "" || host.rep != e); i++)
            @(posedge pclk);
        num_checks++;
        if (host.rep != e) begin
            err_count++;
            $display("MISMATCH reply %s exp %s got %s", c, e, host.rep);
        end
    endtask
    // Pulse a gate request; grant or deny shows one cycle later
    task automatic gate(bit f, logic g);
        @(posedge pclk);
        if (f) cfg_req <= 1'b1;
        else cal_req <= 1'b1;
        @(posedge pclk);
        {cfg_req, cal_req} <= 2'b00;
        #1;
        ck("gate", {31'h0, g, !g},
           f ? {31'h0, cfg_grant, cfg_deny} : {31'h0, cal_grant, cal_deny});
    endtask
    task automatic t_regs();
        apb(1'b0, 12'h000);
        ck("ctrl", 33'h000000001, rd);
        apb(1'b0, 12'h004);
        ck("status", 33'h0, rd);
        apb(1'b1, 12'h004, 32'hffffffff);
        apb(1'b0, 12'h010);
        ck("unmapped", 33'h100000000, rd);
        apb(1'b0, 12'h004);
        ck("status ro", 33'h0, rd);
        $display("test regs done");
    endtask
    task automatic t_misc();
        host.slow = 1'b1;
        xf("~01D04", "!01");
        ck("sat", 33'h1, range_saturation_select);
        xf("~01D", "!0104");
        xf("~02D", "");
        rx_error <= 1'b1;
        xf("~01D00", "");
        rx_error <= 1'b0;
        xf("~01D00", "!01");
        ck("sat", 33'h0, range_saturation_select);
        host.slow = 1'b0;
        $display("test misc done");
    endtask
    task automatic t_cal();
        gate(1'b0, 1'b0);
        xf("~01E1", "!01");
        gate(1'b0, 1'b1);
        xf("~01E2", "?01");
        xf("~01E0", "!01");
        gate(1'b0, 1'b0);
        $display("test cal done");
    endtask
    task automatic t_soft();
        gate(1'b1, 1'b0);
        xf("~01T3D", "?01");
        xf("~01T3C", "!01");
        xf("~01T02", "!01");
        xf("~01I", "!01");
        ck("open", 33'h1, soft_init_open);
        gate(1'b1, 1'b1);
        ck("open", 33'h0, soft_init_open);
        xf("~01I", "!01");
        repeat (2 * SEC + 4) @(posedge pclk);
        ck("open", 33'h0, soft_init_open);
        gate(1'b1, 1'b0);
        apb(1'b0, 12'h004);
        ck("tmo", 33'h000000200, rd);
        xf("~01T00", "!01");
        xf("~01I", "!01");
        ck("open", 33'h0, soft_init_open);
        $display("test soft init done");
    endtask
    task automatic t_lbl_wdt();
        xf("~01OABC", "!01");
        apb(1'b0, 12'h008);
        ck("label", 33'h000434241, rd);
        apb(1'b0, 12'h00c);
        ck("length", 33'h003000000, rd);
        xf("~01OABCDEFG", "");
        wdt_enabled <= 1'b1;
        wdt_timeout <= 1'b1;
        @(posedge pclk);
        wdt_timeout <= 1'b0;
        xf("~010", "!0184");
        xf("~011", "!01");
        xf("~010", "!0180");
        xf("~**", "");
        $display("test label watchdog done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Reset, scenarios, verdict; watchdog cuts a hang short
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_misc();
        t_cal();
        t_soft();
        t_lbl_wdt();
        tally_and_finish();
    end
    initial begin
        #1000000;
        err_count++;
        tally_and_finish();
    end
endmodule
